// ---- pcp_link.sv ----
// link clock side: pin clock divider, output data launch and rmii input capture
`timescale 1ns/1ps
`include "pcp_regs.svh"
module pcp_link (
   input  wire logic       link_clk,
   input  wire logic       resetn,
   input  wire logic [3:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic [1:0] port_in_data,
   input  wire logic       port_in_data_valid,
   pcp_link_if.link        lk
);
   pcp_pkg::pcp_link_t s_reg;
   pcp_pkg::pcp_link_t s_next;
   logic               adv;
   logic               smp;

   // next state of the link side
   always_comb begin
      s_next = s_reg;
      s_next.drv_s1 = lk.drive_clk;
      s_next.drv_s2 = s_reg.drv_s1;
      s_next.rmii_s1 = lk.rmii;
      s_next.rmii_s2 = s_reg.rmii_s1;
      // divide by two when the pin clock is ours
      s_next.clk_o = s_reg.drv_s2 ? ~s_reg.clk_o : 1'h0;
      adv = s_reg.drv_s2 ? s_reg.clk_o : 1'h1; // falling pin edge
      smp = s_reg.drv_s2 ? ~s_reg.clk_o : 1'h1; // rising pin edge
      s_next.tx_take = adv;
      if (adv) begin // R1 R2 R5
         s_next.out_data = s_reg.rmii_s2 ? {`PCP_PAIR_ZERO, tx_data[1:0]} : tx_data;
         s_next.out_valid = tx_valid;
      end
      if (s_reg.rmii_s2 && smp) begin // R5
         s_next.in_data = port_in_data;
         s_next.in_valid = port_in_data_valid;
      end else if (!s_reg.rmii_s2) begin
         s_next.in_data = `PCP_PAIR_ZERO;
         s_next.in_valid = 1'h0;
      end
   end

   // link side register
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lk.clk_o = s_reg.clk_o;
   assign lk.tx_take = s_reg.tx_take;
   assign lk.out_data = s_reg.out_data;
   assign lk.out_valid = s_reg.out_valid;
   assign lk.in_data = s_reg.in_data;
   assign lk.in_valid = s_reg.in_valid;

   // rmii input pair follows the pins one edge later
   rmii_capture_a: assert property (@(posedge link_clk) disable iff (!resetn) // R5
      (s_reg.rmii_s2 && !s_reg.drv_s2) |=> (s_reg.in_data == $past(port_in_data)))
      else $error("rmii input pair not captured");
   // pin clock toggles every edge while driven
   clk_divide_a: assert property (@(posedge link_clk) disable iff (!resetn) // R2
      s_reg.drv_s2 [*2] |-> (s_reg.clk_o != $past(s_reg.clk_o)))
      else $error("driven pin clock did not toggle");
endmodule

// ---- pcp_link_if.sv ----
// carrier between the mode logic and the link clock logic
`timescale 1ns/1ps
interface pcp_link_if;
   logic       drive_clk; // level: device drives the pin clock
   logic       rmii;      // level: rmii framing
   logic       clk_o;
   logic       tx_take;
   logic [3:0] out_data;
   logic       out_valid;
   logic [1:0] in_data;
   logic       in_valid;
   modport cfg  (output drive_clk, output rmii, input clk_o, input tx_take,
                 input out_data, input out_valid, input in_data, input in_valid);
   modport link (input drive_clk, input rmii, output clk_o, output tx_take,
                 output out_data, output out_valid, output in_data, output in_valid);
endinterface

// ---- pcp_phy_model.sv ----
// model of the external phy or mac facing the port clock and collision pins
`timescale 1ns/1ps
module pcp_phy_model (
   input  wire logic       link_clk,
   input  wire logic       clk_src,
   input  wire logic       col_src,
   input  wire logic       col_req,
   input  wire logic [1:0] in_pat,
   output logic            clk_drv,
   output logic            clk_en,
   output logic            col_drv,
   output logic            col_en,
   output logic [1:0]      port_in_data = 2'h0,
   output logic            port_in_data_valid = 1'b0
);
   // far side sources the pin clock when it is the clock master
   assign clk_en  = clk_src;
   assign clk_drv = link_clk;
   // phy side reports collisions only while it owns the pin
   assign col_en  = col_src;
   assign col_drv = col_req;
   // rmii data launched off the falling edge so the device samples it settled
   always @(negedge link_clk) begin
      port_in_data       <= in_pat;
      port_in_data_valid <= 1'b1;
   end
endmodule

// ---- pcp_pins.sv ----
// Operation
// [R1] mac mode: clock pin is an input from the phy, times output data
// [R2] mii phy mode: device drives the clock pin for the external mac
// [R3] isolate set: clock pin output driver off in any phy mode
// [R4] 200 mbps phy mode: strength bit picks 12 or 16 ma drive
// [R5] rmii mode: 50 mhz pin clock times both data pairs and valids
// [R6] rmii mode: direction bit 0 makes clock an input, 1 an output
// [R7] rmii input clock: pull-down on; isolate turns buffer and pull-down off
// [R8] rmii output clock: buffer and pull-down off, strength bit picks drive
// [R9] internal phy mode: clock and collision pins unused
// [R10] mac mode: external phy drives collision into the device
// [R11] mii phy mode: collision is an output, off while isolate set
// [R12] rmii mode: collision pin unused
// [R13] three bit strap selects the port mode
// [R14] strap captured at power-on and each external reset release
`timescale 1ns/1ps
`include "pcp_regs.svh"
module pcp_pins (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       link_clk,
   input  wire logic       external_reset_n,
   input  wire logic [2:0] port_mode_strap,
   input  wire logic       isolate,
   input  wire logic       clk_strength,
   input  wire logic       clk_dir,
   input  wire logic       core_collision,
   input  wire logic       port_out_ref_clock_i,
   output logic            port_out_ref_clock_o,
   output logic            port_out_ref_clock_oe,
   output logic            clk_pulldown_en,
   output logic            clk_inbuf_en,
   output logic            clk_drive_16ma,
   input  wire logic       port_collision_pin_i,
   output logic            port_collision_pin_o,
   output logic            port_collision_pin_oe,
   output logic            col_pullup_en,
   output logic            col_inbuf_en,
   output logic            collision_detected,
   output logic [2:0]      port_mode,
   output logic            mode_valid,
   input  wire logic [3:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_take,
   output logic [3:0]      port_out_data,
   output logic            port_out_data_valid,
   input  wire logic [1:0] port_in_data,
   input  wire logic       port_in_data_valid,
   output logic [1:0]      rx_data,
   output logic            rx_valid
);
   // whole ref_clk side state, one register
   pcp_pkg::pcp_top_t s_reg;
   pcp_pkg::pcp_top_t s_next;
   pcp_link_if        lk ();

   // mode class decode, used for both pins
   function automatic logic is_phy(input pcp_pkg::pcp_mode_t m);
      is_phy = (m == `PCP_MODE_PHY) || (m == `PCP_MODE_PHY200LO) ||
               (m == `PCP_MODE_PHY200HI);
   endfunction

   // 200 mbps codes carry the drive choice
   function automatic logic is_phy200(input pcp_pkg::pcp_mode_t m);
      is_phy200 = (m == `PCP_MODE_PHY200LO) || (m == `PCP_MODE_PHY200HI);
   endfunction

   // rmii codes, whichever way the clock points
   function automatic logic is_rmii(input pcp_pkg::pcp_mode_t m);
      is_rmii = (m == `PCP_MODE_RMII_OLO) || (m == `PCP_MODE_RMII_OHI) ||
                (m == `PCP_MODE_RMII_IN);
   endfunction

   // next state: synchronisers, strap capture and pin controls
   always_comb begin
      s_next = s_reg;
      // two flops on the reset, strap and collision pin inputs
      // control bits come from same-clock registers, no sync
      s_next.ext_s1 = external_reset_n;
      s_next.ext_s2 = s_reg.ext_s1;
      s_next.strap_s1 = port_mode_strap;
      s_next.strap_s2 = s_reg.strap_s1;
      s_next.col_s1 = port_collision_pin_i;
      s_next.col_s2 = s_reg.col_s1;

      // strap capture sequence
      case (s_reg.st)
         pcp_pkg::PCP_ST_SETTLE: begin
            // wait for the strap synchroniser to fill after power-on
            if (s_reg.cnt == `PCP_SETTLE_CYC) begin
               s_next.mode = s_reg.strap_s2; // R13 R14
               s_next.st = pcp_pkg::PCP_ST_RUN;
               s_next.cnt = `PCP_CNT_ZERO;
            end else begin
               s_next.cnt = s_reg.cnt + `PCP_CNT_ONE;
            end
         end
         pcp_pkg::PCP_ST_RUN: begin
            // external reset low: freeze the pin setup
            if (!s_reg.ext_s2) begin
               s_next.st = pcp_pkg::PCP_ST_HOLD;
            end
         end
         pcp_pkg::PCP_ST_HOLD: begin
            // external reset released: take the strap again
            if (s_reg.ext_s2) begin
               s_next.mode = s_reg.strap_s2; // R14
               s_next.st = pcp_pkg::PCP_ST_RUN;
            end
         end
         default: begin
            // stray encoding: restart the capture
            s_next.st = pcp_pkg::PCP_ST_SETTLE;
            s_next.cnt = `PCP_CNT_ZERO;
         end
      endcase
      // capture done, registered for mode_valid
      s_next.mode_ok = (s_next.st == pcp_pkg::PCP_ST_RUN);

      // quiet defaults, as for an unused pin
      // every pad control recomputed each edge
      s_next.clk_oe = 1'h0;
      s_next.clk_pd_en = 1'h0;
      s_next.clk_ib_en = 1'h0;
      s_next.clk_drv16 = 1'h0;
      s_next.col_o = 1'h0;
      s_next.col_oe = 1'h0;
      s_next.col_pu_en = 1'h0;
      s_next.col_ib_en = 1'h0;
      s_next.col_det = 1'h0;
      s_next.drive_clk = 1'h0;
      s_next.rmii = 1'h0;

      // clock pin
      if (s_reg.mode == `PCP_MODE_MAC) begin
         // phy transmit clock comes in
         // pull-down holds the pin if no phy is fitted
         s_next.clk_ib_en = 1'h1; // R1
         s_next.clk_pd_en = 1'h1;
      end else if (is_phy(s_reg.mode)) begin
         // link side divides its clock for the pin
         s_next.drive_clk = 1'h1; // R2
         s_next.clk_oe = !isolate; // R2 R3
         // only 200 mbps codes take the strength bit
         if (is_phy200(s_reg.mode)) begin
            s_next.clk_drv16 = clk_strength; // R4
         end
      end else if (is_rmii(s_reg.mode)) begin
         s_next.rmii = 1'h1; // R5
         // direction bit, not the strap, picks the role
         if (clk_dir) begin // R6
            s_next.drive_clk = 1'h1;
            s_next.clk_oe = !isolate; // R3 R8
            s_next.clk_drv16 = clk_strength; // R8
         end else begin
            // input clock: isolate drops buffer and pull
            s_next.clk_ib_en = !isolate; // R7
            s_next.clk_pd_en = !isolate; // R7
         end
      end else begin
         // internal phy: pull-down kept, nothing else
         s_next.clk_pd_en = 1'h1; // R9
      end

      // collision pin
      // mac input passes the two-flop sync first
      if (s_reg.mode == `PCP_MODE_MAC) begin
         s_next.col_ib_en = 1'h1; // R10
         s_next.col_pu_en = 1'h1;
         s_next.col_det = s_reg.col_s2; // R10
      end else if (is_phy(s_reg.mode)) begin
         s_next.col_o = core_collision; // R11
         s_next.col_oe = !isolate; // R11
      end else if (is_rmii(s_reg.mode)) begin
         // rmii carries no collision signal
         s_next.col_oe = 1'h0; // R12
      end else begin
         s_next.col_pu_en = 1'h1; // R9
      end
   end

   // async reset gives the quiet internal setup
   // the one state register of this side
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
         s_reg.st <= pcp_pkg::PCP_ST_SETTLE;
         s_reg.mode <= `PCP_MODE_RESET;
         // sync starts released: no false hold
         s_reg.ext_s1 <= 1'h1;
         s_reg.ext_s2 <= 1'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   // mode levels to the link side, synchronised there
   // slow levels, changed at capture or by the rmii direction bit
   assign lk.drive_clk = s_reg.drive_clk;
   assign lk.rmii = s_reg.rmii;

   // link clock logic
   // clock divide and rmii pair capture
   pcp_link u_link (
      .link_clk           (link_clk),
      .resetn             (resetn),
      .tx_data            (tx_data),
      .tx_valid           (tx_valid),
      .port_in_data       (port_in_data),
      .port_in_data_valid (port_in_data_valid),
      .lk                 (lk.link)
   );

   // pin controls straight from flops
   // they follow the mode one edge later
   assign port_out_ref_clock_oe = s_reg.clk_oe;
   assign clk_pulldown_en = s_reg.clk_pd_en;
   assign clk_inbuf_en = s_reg.clk_ib_en;
   assign clk_drive_16ma = s_reg.clk_drv16;
   assign port_collision_pin_o = s_reg.col_o;
   assign port_collision_pin_oe = s_reg.col_oe;
   assign col_pullup_en = s_reg.col_pu_en;
   assign col_inbuf_en = s_reg.col_ib_en;
   assign collision_detected = s_reg.col_det;
   assign port_mode = s_reg.mode;
   assign mode_valid = s_reg.mode_ok;

   // link side flops
   // already registered on link_clk
   assign port_out_ref_clock_o = lk.clk_o;
   assign tx_take = lk.tx_take;
   assign port_out_data = lk.out_data;
   assign port_out_data_valid = lk.out_valid;
   assign rx_data = lk.in_data;
   assign rx_valid = lk.in_valid;

   // pad checks: one edge after mode and bits
   // mac mode never drives the clock pin, buffer on
   mac_clk_input_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
      (s_reg.mode == `PCP_MODE_MAC) |=> (!s_reg.clk_oe && s_reg.clk_ib_en))
      else $error("mac mode clock pin not an input");

   // phy mode drives the clock when not isolated
   phy_clk_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
      (is_phy(s_reg.mode) && !isolate) |=> (s_reg.clk_oe && s_reg.drive_clk))
      else $error("phy mode clock pin not driven");

   // isolate removes the clock driver in phy modes
   iso_clk_off_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R3
      ((is_phy(s_reg.mode) || is_rmii(s_reg.mode)) && isolate) |=> !s_reg.clk_oe)
      else $error("clock driver on while isolated");

   // 200 mbps drive strength follows the bit
   phy200_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
      is_phy200(s_reg.mode) |=> (s_reg.clk_drv16 == $past(clk_strength)))
      else $error("200 mbps clock drive wrong");

   // rmii direction bit sets the clock pin role
   rmii_dir_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R6
      (is_rmii(s_reg.mode) && !isolate) |=> (s_reg.clk_oe == $past(clk_dir)))
      else $error("rmii clock direction wrong");

   // rmii input clock pull-down and buffer
   rmii_clk_in_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R7
      (is_rmii(s_reg.mode) && !clk_dir) |=>
         (s_reg.clk_pd_en == !$past(isolate)) && (s_reg.clk_ib_en == !$past(isolate)))
      else $error("rmii input clock pad control wrong");

   // rmii output clock: no buffer, no pull-down, chosen drive
   rmii_clk_out_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R8
      (is_rmii(s_reg.mode) && clk_dir) |=>
         (!s_reg.clk_pd_en && !s_reg.clk_ib_en && s_reg.clk_drv16 == $past(clk_strength)))
      else $error("rmii output clock pad control wrong");

   // internal phy leaves both pins undriven
   int_unused_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R9
      (s_reg.mode == `PCP_MODE_INT) |=>
         (!s_reg.clk_oe && !s_reg.col_oe && !s_reg.clk_ib_en && !s_reg.col_det))
      else $error("internal phy mode uses a pin");

   // mac collision input reaches the core
   mac_col_in_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
      (s_reg.mode == `PCP_MODE_MAC) [*2] |-> (s_reg.col_det == $past(s_reg.col_s2)))
      else $error("collision input not passed on");

   // phy collision output and its isolate gate
   phy_col_out_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R11
      is_phy(s_reg.mode) |=>
         (s_reg.col_oe == !$past(isolate)) && (s_reg.col_o == $past(core_collision)))
      else $error("phy collision output wrong");

   // rmii leaves the collision pin alone
   rmii_col_off_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R12
      is_rmii(s_reg.mode) |=> (!s_reg.col_oe && !s_reg.col_det && !s_reg.col_ib_en))
      else $error("collision pin used in rmii");

   // power-on capture within the settle window
   poweron_capture_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
      (s_reg.st == pcp_pkg::PCP_ST_SETTLE && s_reg.cnt == `PCP_SETTLE_CYC) |=>
         (s_reg.mode == $past(s_reg.strap_s2)) && (s_reg.st == pcp_pkg::PCP_ST_RUN))
      else $error("strap not captured after power-on");

   // recapture on release of the external reset
   ext_capture_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
      (s_reg.st == pcp_pkg::PCP_ST_HOLD && s_reg.ext_s2) |=>
         (s_reg.mode == $past(s_reg.strap_s2)))
      else $error("strap not captured at external reset release");

   // a released external reset is seen within a few cycles
   ext_release_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
      ($rose(external_reset_n) && s_reg.st == pcp_pkg::PCP_ST_HOLD) |->
         ##[1:4] (s_reg.st == pcp_pkg::PCP_ST_RUN))
      else $error("external reset release missed");

   // running mode ignores strap changes
   run_mode_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
      (s_reg.st == pcp_pkg::PCP_ST_RUN) |=> (s_reg.mode == $past(s_reg.mode)))
      else $error("mode changed while running");

   // external reset held low keeps the old mode
   hold_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
      (s_reg.st == pcp_pkg::PCP_ST_HOLD && !s_reg.ext_s2) |=>
         (s_reg.mode == $past(s_reg.mode)) && (s_reg.st == pcp_pkg::PCP_ST_HOLD))
      else $error("hold left early");

   // settle counter steps once per edge
   settle_count_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
      (s_reg.st == pcp_pkg::PCP_ST_SETTLE && s_reg.cnt != `PCP_SETTLE_CYC) |=>
         (s_reg.cnt == $past(s_reg.cnt) + `PCP_CNT_ONE))
      else $error("settle count stalled");

   // plain mii phy clock keeps the low drive
   phy_low_drive_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
      (s_reg.mode == `PCP_MODE_PHY) |=> !s_reg.clk_drv16)
      else $error("mii phy clock drive not low");

   // mac collision pin is a pulled-up input
   mac_col_pads_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
      (s_reg.mode == `PCP_MODE_MAC) |=> (!s_reg.col_oe && s_reg.col_ib_en && s_reg.col_pu_en))
      else $error("mac collision pad wrong");

   // internal phy keeps both pad pulls, no input
   int_pulls_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R9
      (s_reg.mode == `PCP_MODE_INT) |=> (s_reg.clk_pd_en && s_reg.col_pu_en && !s_reg.col_ib_en))
      else $error("internal phy pad pulls wrong");

   // isolate drops both drivers in mii phy modes
   phy_col_iso_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R11
      (is_phy(s_reg.mode) && isolate) |=> (!s_reg.col_oe && !s_reg.clk_oe))
      else $error("phy pin driven while isolated");
endmodule

// ---- pcp_pkg.sv ----
// types shared by the port clock and collision pin logic
package pcp_pkg;
   typedef logic [2:0] pcp_mode_t;

   // strap capture sequence
   typedef enum logic [1:0] {
      PCP_ST_SETTLE,
      PCP_ST_RUN,
      PCP_ST_HOLD
   } pcp_state_t;

   // state of the reference clock side
   typedef struct packed {
      pcp_state_t st;
      logic [1:0] cnt;
      pcp_mode_t  mode;
      logic       ext_s1;
      logic       ext_s2;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic       col_s1;
      logic       col_s2;
      logic       clk_oe;
      logic       clk_pd_en;
      logic       clk_ib_en;
      logic       clk_drv16;
      logic       col_o;
      logic       col_oe;
      logic       col_pu_en;
      logic       col_ib_en;
      logic       col_det;
      logic       drive_clk;
      logic       rmii;
      logic       mode_ok;
   } pcp_top_t;

   // state of the link clock side
   typedef struct packed {
      logic       drv_s1;
      logic       drv_s2;
      logic       rmii_s1;
      logic       rmii_s2;
      logic       clk_o;
      logic       tx_take;
      logic [3:0] out_data;
      logic       out_valid;
      logic [1:0] in_data;
      logic       in_valid;
   } pcp_link_t;
endpackage

// ---- pcp_regs.svh ----
// mode codes and timing counts for the port clock and collision pins
`ifndef PCP_REGS_SVH
`define PCP_REGS_SVH
// port mode strap encodings
`define PCP_MODE_MAC      3'h0
`define PCP_MODE_PHY      3'h1
`define PCP_MODE_PHY200LO 3'h2
`define PCP_MODE_PHY200HI 3'h3
`define PCP_MODE_RMII_OLO 3'h4
`define PCP_MODE_RMII_OHI 3'h5
`define PCP_MODE_RMII_IN  3'h6
`define PCP_MODE_INT      3'h7
// reset value of the captured mode: everything quiet
`define PCP_MODE_RESET    3'h7
// cycles to wait after reset release before the strap is sampled
`define PCP_SETTLE_CYC    2'h2
`define PCP_CNT_ONE       2'h1
`define PCP_CNT_ZERO      2'h0
`define PCP_NIB_ZERO      4'h0
`define PCP_PAIR_ZERO     2'h0
`endif

// ---- tb_pcp_pins.sv ----
// self-checking bench for the port clock and collision pin logic
`timescale 1ns/1ps
`include "pcp_regs.svh"
module tb_pcp_pins;
   logic ref_clk, resetn, link_clk, external_reset_n, isolate, clk_strength, clk_dir;
   logic core_collision, clk_pin, col_pin, tx_valid, tx_take, rx_valid, mode_valid;
   logic port_out_ref_clock_o, port_out_ref_clock_oe, clk_pulldown_en, clk_inbuf_en;
   logic clk_drive_16ma, port_collision_pin_o, port_collision_pin_oe, col_pullup_en;
   logic col_inbuf_en, collision_detected, port_out_data_valid, port_in_data_valid;
   logic clk_src, col_src, col_req, clk_drv, clk_en, col_drv, col_en, a;
   logic [2:0] port_mode_strap, port_mode;
   logic [3:0] tx_data, port_out_data;
   logic [1:0] port_in_data, rx_data, in_pat;
   int         n_mismatch = 0;
   int         n_tests = 0;

   // pin levels resolved from every party's enable, with pad pulls
   assign clk_pin = port_out_ref_clock_oe ? port_out_ref_clock_o : (clk_en ? clk_drv : 1'b0);
   assign col_pin = port_collision_pin_oe ? port_collision_pin_o : (col_en ? col_drv : 1'b1);

   pcp_pins i_pcp_pins (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk),
      .external_reset_n(external_reset_n), .port_mode_strap(port_mode_strap),
      .isolate(isolate), .clk_strength(clk_strength), .clk_dir(clk_dir),
      .core_collision(core_collision), .port_out_ref_clock_i(clk_pin),
      .port_out_ref_clock_o(port_out_ref_clock_o), .port_out_ref_clock_oe(port_out_ref_clock_oe),
      .clk_pulldown_en(clk_pulldown_en), .clk_inbuf_en(clk_inbuf_en),
      .clk_drive_16ma(clk_drive_16ma), .port_collision_pin_i(col_pin),
      .port_collision_pin_o(port_collision_pin_o), .port_collision_pin_oe(port_collision_pin_oe),
      .col_pullup_en(col_pullup_en), .col_inbuf_en(col_inbuf_en),
      .collision_detected(collision_detected), .port_mode(port_mode), .mode_valid(mode_valid),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_take(tx_take), .port_out_data(port_out_data),
      .port_out_data_valid(port_out_data_valid), .port_in_data(port_in_data),
      .port_in_data_valid(port_in_data_valid), .rx_data(rx_data), .rx_valid(rx_valid));

   pcp_phy_model i_pcp_phy_model (.link_clk(link_clk), .clk_src(clk_src), .col_src(col_src),
      .col_req(col_req), .in_pat(in_pat), .clk_drv(clk_drv), .clk_en(clk_en),
      .col_drv(col_drv), .col_en(col_en), .port_in_data(port_in_data),
      .port_in_data_valid(port_in_data_valid));

   // 40 mhz system clock and unrelated 12 ns link clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.3;
      forever #6 link_clk = ~link_clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // new strap taken at the release of the external reset pin
   task automatic set_mode(input logic [2:0] m);
      @(negedge ref_clk);
      port_mode_strap = m;
      clk_dir = (m == `PCP_MODE_RMII_OLO) || (m == `PCP_MODE_RMII_OHI);
      clk_strength = m[0];
      clk_src = (m == `PCP_MODE_MAC) || (m == `PCP_MODE_RMII_IN);
      col_src = (m == `PCP_MODE_MAC);
      repeat (4) @(negedge ref_clk);
      external_reset_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      external_reset_n = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask

   // pad controls {oe, pd, ib, 16ma, col oe, col pu, col ib}, masked per mode
   task automatic chk_pins(input logic [2:0] m, input logic iso);
      logic [6:0] e, k, g;
      g = {port_out_ref_clock_oe, clk_pulldown_en, clk_inbuf_en, clk_drive_16ma,
           port_collision_pin_oe, col_pullup_en, col_inbuf_en};
      case (m)
         3'h0: begin e = 7'b0110011; k = 7'b1110111; end
         3'h1, 3'h2, 3'h3: begin e = {!iso, 2'b00, m[1] & m[0], !iso, 2'b00}; k = 7'b1001100; end
         3'h4, 3'h5: begin e = {!iso, 2'b00, m[0], 3'b000}; k = 7'b1111111; end
         3'h6: begin e = {1'b0, !iso, !iso, 4'b0000}; k = 7'b1110111; end
         default: begin e = 7'b0100010; k = 7'b1110111; end
      endcase
      chk("pin controls", {1'b0, e & k}, {1'b0, g & k});
   endtask

   // hold data until the device marks a load, then compare the pin data
   task automatic link_send(input logic [3:0] d, input logic [3:0] exp);
      int n;
      n = 0;
      @(negedge link_clk);
      tx_data = d;
      tx_valid = 1'b1;
      @(posedge link_clk);
      #1;
      while (tx_take !== 1'b1 && n < 8) begin
         @(posedge link_clk);
         #1;
         n++;
      end
      chk("tx_take", 8'h01, {7'h00, tx_take});
      chk("port_out_data", {4'h0, exp}, {4'h0, port_out_data});
      chk("port_out_data_valid", 8'h01, {7'h00, port_out_data_valid});
   endtask

   // watchdog far beyond the expected run length
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end

   initial begin
      resetn = 1'b0; external_reset_n = 1'b1; port_mode_strap = 3'h0; isolate = 1'b0;
      clk_strength = 1'b0; clk_dir = 1'b0; core_collision = 1'b0; tx_data = 4'h0;
      tx_valid = 1'b0; clk_src = 1'b1; col_src = 1'b1; col_req = 1'b0; in_pat = 2'h0;
      repeat (12) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk("power-on port_mode", 8'h00, {5'h00, port_mode});
      // every strap code, with and without isolate
      for (int i = 0; i < 8; i++) begin
         set_mode(3'(i));
         chk("port_mode", {5'h00, 3'(i)}, {5'h00, port_mode});
         chk("mode_valid", 8'h01, {7'h00, mode_valid});
         for (int s = 0; s < 2; s++) begin
            isolate = s[0];
            repeat (3) @(negedge ref_clk);
            chk_pins(3'(i), s[0]);
         end
         isolate = 1'b0;
         repeat (3) @(negedge ref_clk);
         if (i == 0) begin
            for (int c = 1; c >= 0; c--) begin
               col_req = c[0];
               repeat (4) @(negedge ref_clk);
               chk("collision_detected", {7'h00, c[0]}, {7'h00, collision_detected});
            end
         end
         if (i == 1) begin
            for (int c = 1; c >= 0; c--) begin
               core_collision = c[0];
               repeat (3) @(negedge ref_clk);
               chk("collision pin", {7'h00, c[0]}, {7'h00, col_pin});
            end
            @(posedge link_clk);
            #1;
            a = port_out_ref_clock_o;
            @(posedge link_clk);
            #1;
            chk("pin clock toggles", {7'h00, ~a}, {7'h00, port_out_ref_clock_o});
         end
         if (i < 7) begin
            link_send(4'ha, (i >= 4) ? 4'h2 : 4'ha);
            link_send(4'h5, (i >= 4) ? 4'h1 : 4'h5);
         end
         if (i >= 4 && i < 7) begin
            for (int p = 1; p < 3; p++) begin
               in_pat = 2'(p);
               repeat (6) @(posedge link_clk);
               #1;
               chk("rx_data", {6'h00, 2'(p)}, {6'h00, rx_data});
               chk("rx_valid", 8'h01, {7'h00, rx_valid});
            end
         end
         $display("mode %0d test done", i);
      end
      // power-on capture again, with a strap other than the reset values
      port_mode_strap = `PCP_MODE_RMII_OHI;
      resetn = 1'b0;
      repeat (12) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk("reset port_mode", {5'h00, `PCP_MODE_RMII_OHI}, {5'h00, port_mode});
      chk("reset mode_valid", 8'h01, {7'h00, mode_valid});
      $display("reset recapture test done");
      test_done();
   end
endmodule
